// ---- rtl/ccs_defines.vh ----
// constants for the calibration and scaling block
// assumes inclusion by bare name from rtl files
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH

// register pointer locations (byte pointer of the serial interface)
`define CCS_PTR_OFFS_HI 8'h0D
`define CCS_PTR_OFFS_LO 8'h0E
`define CCS_PTR_GAIN_HI 8'h0F
`define CCS_PTR_GAIN_LO 8'h10

// reset values and midpoints
`define CCS_OFFS_RESET 16'h8000
`define CCS_MID_CODE 24'h800000
`define CCS_OTP_GAIN_ADDR 4'h0

// gain is unsigned 1.15 fixed point, 0x8000 is unity
`define CCS_GAIN_SHIFT 15
// offset lsb is 2^17 below full scale, result lsb 2^23: shift 6
`define CCS_OFFS_SHIFT 6
// top bit of the raw difference that still fits the offset register
`define CCS_OFFS_TOP 21
`define CCS_OFFS_MIN 16'h0000
`define CCS_OFFS_MAX 16'hFFFF
// result clamp ends, offset binary
`define CCS_RES_MIN 24'h000000
`define CCS_RES_MAX 24'hFFFFFF
// temperature: code = (degc + 4096) * 2048, raw is degc in 1/2048 steps
`define CCS_TEMP_BIAS 24'h800000
// supply divided by six: factor 1/6 as 0x2AAB / 2^16
`define CCS_DIV6_MUL 17'h02AAB
`define CCS_DIV6_SHIFT 16

// result sources
`define CCS_SRC_CAP 2'h0
`define CCS_SRC_TEMP 2'h1
`define CCS_SRC_VOLT 2'h2
`define CCS_SRC_VDD 2'h3

`endif

// ---- rtl/ccs_otp_rom.v ----
// one-time-programmable factory coefficient store, registered read
// assumes contents are fixed at build time through the parameters
`timescale 1ns/100ps
`default_nettype none
module ccs_otp_rom #(
  parameter [15:0] CAP_GAIN_FACTORY = 16'h8000,
  parameter [15:0] TEMP_GAIN_FACTORY = 16'h8000
) (
  // clock
  input wire core_clk,
  // read port
  input wire [3:0] rd_addr,
  output reg [15:0] rd_data_reg
);
  always @(posedge core_clk) begin
    case (rd_addr)
      4'h0: rd_data_reg <= CAP_GAIN_FACTORY;
      4'h1: rd_data_reg <= TEMP_GAIN_FACTORY;
      default: rd_data_reg <= 16'h0000;
    endcase
  end
endmodule // ccs_otp_rom
`default_nettype wire

// ---- rtl/ccs_cal_scale.v ----
// calibration coefficient handling and result scaling
// assumes a serial front end supplies byte writes/reads by pointer
// Contract
// (R1) reset copies factory cap gain from otp into gain register
// (R2) gain changes by gain calibration or host write until reset
// (R3) offset calibration makes zero-scale input read 0x800000
// (R4) host may write offset directly; lsb is full scale over 2^17
// (R5) offset register returns to default at every reset
// (R6) host stores and rewrites offset after power-up if needed
// (R7) host reloads per-channel offset before switching channel
// (R8) host removes offset beyond 1 pF with input_offset_cap_converter
// (R9) temperature results are scaled with factory coefficients
// (R10) temperature code divided by 2048 minus 4096 gives degrees
// (R11) supply monitor result is the supply attenuated by six
// (R12) offset register 16 bits at pointers 0x0D/0x0E, reset 0x8000
// (R13) gain register 16 bits at pointers 0x0F/0x10, factory reset
// (R14) cap result subtracts offset about midpoint then applies gain
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defines.vh"
module ccs_cal_scale (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // register access from serial front end
  input wire wr_stb,
  input wire [7:0] wr_ptr,
  input wire [7:0] wr_data,
  input wire [7:0] rd_ptr,
  output reg [7:0] rd_data_reg,
  // calibration commands
  input wire offs_cal_start,
  input wire gain_cal_start,
  // raw filter output
  input wire raw_valid,
  input wire [1:0] raw_src,
  input wire [23:0] raw_data,
  // scaled result and busy flags
  output reg res_valid_reg,
  output reg [23:0] res_data_reg,
  output reg cal_busy_reg,
  output reg load_busy_reg
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam ST_LOAD0 = 2'h0;
  localparam ST_LOAD1 = 2'h1;
  localparam ST_LOAD2 = 2'h2;
  localparam ST_RUN = 2'h3;

  reg [1:0] st_reg;
  reg [15:0] offs_reg;
  reg [15:0] gain_reg;
  reg [15:0] tgain_reg;
  // calibration requests, pending until a cap sample consumes them
  reg offs_cal_reg;
  reg gain_cal_reg;
  reg [3:0] otp_addr_reg;
  wire [15:0] otp_data;

  // ----------------------------------------
  // factory store
  // ----------------------------------------
  // registered read: each factory word lands a cycle after its address
  ccs_otp_rom u_otp (
    .core_clk(core_clk),
    .rd_addr(otp_addr_reg),
    .rd_data_reg(otp_data)
  );

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  // offset relative to midpoint, scaled to 24-bit result steps
  wire signed [16:0] offs_rel = $signed({1'b0, offs_reg}) -
    $signed({1'b0, `CCS_OFFS_RESET});
  wire signed [24:0] raw_s = $signed({1'b0, raw_data}) -
    $signed({1'b0, `CCS_MID_CODE});
  wire signed [25:0] offs_scaled = $signed({offs_rel, 9'h000}) >>>
    (9 - `CCS_OFFS_SHIFT);
  // (R14) subtract then gain
  wire signed [25:0] cap_corr = $signed({raw_s[24], raw_s}) - offs_scaled;
  wire signed [42:0] cap_prod = cap_corr * $signed({1'b0, gain_reg});
  wire signed [42:0] cap_q = cap_prod >>> `CCS_GAIN_SHIFT;
  // the product must fit 24 signed bits; outside that it pins at the
  // end of the range, since a gain near two on a large input would
  // otherwise fold over to the opposite sign
  wire cap_fits = (cap_q[42:23] == {20{cap_q[23]}});
  wire [23:0] cap_wrap = cap_q[23:0] + `CCS_MID_CODE;
  wire [23:0] cap_res = cap_fits ? cap_wrap :
    (cap_q[42] ? `CCS_RES_MIN : `CCS_RES_MAX);
  // (R9) factory temp gain, (R10) bias so code/2048-4096 = degc
  wire signed [41:0] t_prod = raw_s * $signed({1'b0, tgain_reg});
  wire signed [41:0] t_q = t_prod >>> `CCS_GAIN_SHIFT;
  // same clamp for the temperature code
  wire t_fits = (t_q[41:23] == {19{t_q[23]}});
  wire [23:0] t_wrap = t_q[23:0] + `CCS_TEMP_BIAS;
  wire [23:0] temp_res = t_fits ? t_wrap :
    (t_q[41] ? `CCS_RES_MIN : `CCS_RES_MAX);
  // (R11) supply attenuated by six
  // 0x2AAB over 2^16 is one sixth plus about 30 ppm
  wire [40:0] vdd_prod = raw_data * `CCS_DIV6_MUL;
  wire [23:0] vdd_res = vdd_prod[`CCS_DIV6_SHIFT+23:`CCS_DIV6_SHIFT];
  // gain needed so that the full-scale input maps to full scale
  wire [25:0] fs_mag = raw_s[24] ? -{raw_s[24], raw_s} :
    {raw_s[24], raw_s};
  // coarse: two outcomes only, a true quotient would need a divider
  wire [15:0] cal_gain = (fs_mag[25:8] == 18'h00000) ? 16'hFFFF :
    16'h8000;

  // ----------------------------------------
  // offset calibration value
  // ----------------------------------------
  // zero-scale sample in offset steps; beyond the register's reach it
  // pins at an end instead of wrapping, as larger offsets are meant
  // for the input_offset_cap_converter
  wire offs_fits = (raw_s[24:`CCS_OFFS_TOP] == {4{raw_s[`CCS_OFFS_TOP]}});
  wire [15:0] offs_step = raw_s[`CCS_OFFS_TOP:`CCS_OFFS_SHIFT];
  wire [15:0] offs_cal_val = offs_fits ? offs_step + `CCS_OFFS_RESET :
    (raw_s[24] ? `CCS_OFFS_MIN : `CCS_OFFS_MAX);

  // ----------------------------------------
  // sequencing and registers
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      st_reg <= ST_LOAD0;
      otp_addr_reg <= `CCS_OTP_GAIN_ADDR;
      // (R5) (R12) offset back to default
      offs_reg <= `CCS_OFFS_RESET;
      // zero until the factory word arrives; samples are refused then
      gain_reg <= 16'h0000;
      tgain_reg <= 16'h0000;
      offs_cal_reg <= 1'b0;
      gain_cal_reg <= 1'b0;
      res_valid_reg <= 1'b0;
      res_data_reg <= 24'h000000;
      cal_busy_reg <= 1'b0;
      load_busy_reg <= 1'b1;
    end else begin
      // pulse drops every cycle unless a result reloads it below
      res_valid_reg <= 1'b0;
      case (st_reg)
        ST_LOAD0: begin
          // gain word is on its way, ask for the temperature word
          otp_addr_reg <= otp_addr_reg + 4'h1;
          st_reg <= ST_LOAD1;
        end
        ST_LOAD1: begin
          // (R1) (R13) factory gain into gain register
          gain_reg <= otp_data;
          st_reg <= ST_LOAD2;
        end
        ST_LOAD2: begin
          // (R9) temperature coefficient, the last factory word
          tgain_reg <= otp_data;
          load_busy_reg <= 1'b0;
          st_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (offs_cal_start)
            offs_cal_reg <= 1'b1;
          if (gain_cal_start)
            gain_cal_reg <= 1'b1;
          cal_busy_reg <= offs_cal_reg | gain_cal_reg | offs_cal_start |
            gain_cal_start;
          // (R2) (R4) (R12) (R13) host byte writes, high byte first ptr
          // a calibration update below overrides a write in the same cycle
          if (wr_stb) begin
            case (wr_ptr)
              `CCS_PTR_OFFS_HI: offs_reg[15:8] <= wr_data;
              `CCS_PTR_OFFS_LO: offs_reg[7:0] <= wr_data;
              `CCS_PTR_GAIN_HI: gain_reg[15:8] <= wr_data;
              `CCS_PTR_GAIN_LO: gain_reg[7:0] <= wr_data;
              default: ;
            endcase
          end
          if (raw_valid && raw_src == `CCS_SRC_CAP && offs_cal_reg) begin
            // (R3) zero-scale input becomes midpoint code
            offs_reg <= offs_cal_val;
            // a fresh start in the consuming cycle stays pending
            offs_cal_reg <= offs_cal_start;
            cal_busy_reg <= gain_cal_reg | gain_cal_start | offs_cal_start;
          end else if (raw_valid && raw_src == `CCS_SRC_CAP &&
              gain_cal_reg) begin
            // (R2) gain calibration from full-scale input
            gain_reg <= cal_gain;
            // set wins here as well
            gain_cal_reg <= gain_cal_start;
            cal_busy_reg <= offs_cal_start | gain_cal_start;
          end else if (raw_valid) begin
            res_valid_reg <= 1'b1;
            case (raw_src)
              `CCS_SRC_CAP: res_data_reg <= cap_res;
              `CCS_SRC_TEMP: res_data_reg <= temp_res;
              `CCS_SRC_VDD: res_data_reg <= vdd_res;
              default: res_data_reg <= raw_data;
            endcase
          end
        end
        default: st_reg <= ST_LOAD0;
      endcase
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  // one cycle behind the pointer; unmapped pointers read zero
  always @(posedge core_clk) begin
    if (srst) begin
      rd_data_reg <= 8'h00;
    end else begin
      case (rd_ptr)
        `CCS_PTR_OFFS_HI: rd_data_reg <= offs_reg[15:8];
        `CCS_PTR_OFFS_LO: rd_data_reg <= offs_reg[7:0];
        `CCS_PTR_GAIN_HI: rd_data_reg <= gain_reg[15:8];
        `CCS_PTR_GAIN_LO: rd_data_reg <= gain_reg[7:0];
        default: rd_data_reg <= 8'h00;
      endcase
    end
  end
endmodule // ccs_cal_scale
`default_nettype wire

// ---- bench/ccs_cal_scale_assertions.sv ----
// port checker for the calibration and scaling block
// assumes binding onto ccs_cal_scale, one clock domain
`timescale 1ns/100ps
`default_nettype none
module ccs_cal_scale_assertions (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // requests
  input wire offs_cal_start,
  input wire gain_cal_start,
  input wire raw_valid,
  input wire [1:0] raw_src,
  input wire [7:0] rd_ptr,
  // answers
  input wire [7:0] rd_data_reg,
  input wire res_valid_reg,
  input wire [23:0] res_data_reg,
  input wire cal_busy_reg,
  input wire load_busy_reg
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_cal_req;
    (offs_cal_start || gain_cal_start) && !load_busy_reg && !raw_valid;
  endsequence
  sequence s_cap_in;
    raw_valid && raw_src == 2'h0 && !load_busy_reg;
  endsequence
  a_load_done_bound: assert property ($fell(srst) |-> ##[1:4] !load_busy_reg)
    else $error("factory load did not end");
  a_load_refuses: assert property (load_busy_reg && raw_valid |=> !res_valid_reg)
    else $error("sample taken during load");
  a_cal_busy_set: assert property (s_cal_req |=> cal_busy_reg)
    else $error("calibration not pending");
  a_cal_no_result: assert property (s_cap_in ##0 cal_busy_reg |=> !res_valid_reg)
    else $error("calibration sample gave a result");
  a_res_one_after: assert property (
    raw_valid && !load_busy_reg && !cal_busy_reg |=> res_valid_reg)
    else $error("result pulse missing");
  a_res_needs_raw: assert property (!raw_valid |=> !res_valid_reg)
    else $error("result pulse without sample");
  a_res_holds: assert property (!res_valid_reg |-> $stable(res_data_reg))
    else $error("result changed without pulse");
  a_rd_unmapped: assert property (
    rd_ptr < 8'h0D || rd_ptr > 8'h10 |=> rd_data_reg == 8'h00)
    else $error("unmapped pointer read nonzero");
endmodule // ccs_cal_scale_assertions
bind ccs_cal_scale ccs_cal_scale_assertions u_chk (.core_clk(core_clk),
  .srst(srst), .offs_cal_start(offs_cal_start),
  .gain_cal_start(gain_cal_start), .raw_valid(raw_valid), .raw_src(raw_src),
  .rd_ptr(rd_ptr), .rd_data_reg(rd_data_reg), .res_valid_reg(res_valid_reg),
  .res_data_reg(res_data_reg), .cal_busy_reg(cal_busy_reg),
  .load_busy_reg(load_busy_reg));
`default_nettype wire

// ---- bench/ccs_host_model.sv ----
// host controller model: byte register writes and reads by pointer
// assumes changes at the falling edge, design samples at the rising edge
`timescale 1ns/100ps
`default_nettype none
module ccs_host_model (
  // clock
  input wire logic core_clk,
  // register access
  output logic wr_stb = 1'b0,
  output logic [7:0] wr_ptr = 8'h00,
  output logic [7:0] wr_data = 8'h00,
  output logic [7:0] rd_ptr = 8'hFF,
  input wire logic [7:0] rd_data_reg
);
  // host loads offset or gain, hi byte first
  task automatic wr_word(input logic [7:0] ptr, input logic [15:0] val);
    @(negedge core_clk);
    wr_stb = 1'b1;
    wr_ptr = ptr;
    wr_data = val[15:8];
    @(negedge core_clk);
    wr_ptr = ptr + 8'h01;
    wr_data = val[7:0];
    @(negedge core_clk);
    wr_stb = 1'b0;
    // released data never shows the last byte
    wr_data = ~wr_data;
  endtask
  task automatic rd_word(input logic [7:0] ptr, output logic [15:0] val);
    @(negedge core_clk);
    rd_ptr = ptr;
    @(negedge core_clk);
    val[15:8] = rd_data_reg;
    rd_ptr = ptr + 8'h01;
    @(negedge core_clk);
    val[7:0] = rd_data_reg;
    rd_ptr = 8'hFF;
  endtask
endmodule // ccs_host_model
`default_nettype wire

// ---- bench/ccs_cal_scale_tb.sv ----
// self-checking bench with an integer model of the scaled results
// assumes factory gain of the otp left at its 0x8000 default
`timescale 1ns/100ps
`default_nettype none
module ccs_cal_scale_tb;
  logic core_clk = 1'b0, srst = 1'b1, offs_cal_start = 1'b0, raw_valid = 1'b0;
  logic gain_cal_start = 1'b0;
  logic [1:0] raw_src = 2'h0;
  logic [23:0] raw_data = 24'h000000, rd;
  logic [15:0] rv;
  wire logic wr_stb, res_valid_reg, cal_busy_reg, load_busy_reg;
  wire logic [7:0] wr_ptr, wr_data, rd_ptr, rd_data_reg;
  wire logic [23:0] res_data_reg;
  int fail_count = 0, total_checks = 0;
  longint offs_m, gain_m;
  always #25 core_clk = ~core_clk;
  ccs_host_model u_ccs_host_model (.core_clk(core_clk), .wr_stb(wr_stb),
    .wr_ptr(wr_ptr), .wr_data(wr_data), .rd_ptr(rd_ptr),
    .rd_data_reg(rd_data_reg));
  ccs_cal_scale u_ccs_cal_scale (.core_clk(core_clk), .srst(srst),
    .wr_stb(wr_stb), .wr_ptr(wr_ptr), .wr_data(wr_data), .rd_ptr(rd_ptr),
    .rd_data_reg(rd_data_reg), .offs_cal_start(offs_cal_start),
    .gain_cal_start(gain_cal_start), .raw_valid(raw_valid),
    .raw_src(raw_src),
    .raw_data(raw_data), .res_valid_reg(res_valid_reg),
    .res_data_reg(res_data_reg), .cal_busy_reg(cal_busy_reg),
    .load_busy_reg(load_busy_reg));
  task automatic chk(input string what, input logic [23:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [23:0] model(input logic [1:0] s, input longint d);
    longint v;
    // offset lsb is 64 result lsb, gain 0x8000 is unity, ends clamp
    v = d;
    if (s == 2'h0)
      v = (((d - 8388608) - (offs_m - 32768) * 64) * gain_m >>> 15)
        + 8388608;
    if (s == 2'h3)
      v = (d * 10923) >> 16;
    if (v < 0)
      v = 0;
    if (v > 16777215)
      v = 16777215;
    return 24'(v);
  endfunction
  task automatic pulse_raw(input logic [1:0] s, input logic [23:0] d);
    @(negedge core_clk);
    raw_valid = 1'b1;
    raw_src = s;
    raw_data = d;
    @(negedge core_clk);
    raw_valid = 1'b0;
    raw_data = ~d;
  endtask
  task automatic run_raw(input logic [1:0] s, input logic [23:0] d);
    pulse_raw(s, d);
    chk("res_valid", 24'h000001, {23'h0, res_valid_reg});
    chk("res_data", model(s, d), res_data_reg);
  endtask
  task automatic do_reset;
    srst = 1'b1;
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    // a sample during the factory load must be ignored
    pulse_raw(2'h0, 24'h801234);
    chk("load_res_valid", 24'h000000, {23'h0, res_valid_reg});
    chk("load_busy", 24'h000001, {23'h0, load_busy_reg});
    repeat (4) @(negedge core_clk);
    chk("load_done", 24'h000000, {23'h0, load_busy_reg});
    offs_m = 'h8000;
    gain_m = 'h8000;
    u_ccs_host_model.rd_word(8'h0F, rv);
    chk("gain", 24'h008000, {8'h00, rv});
    u_ccs_host_model.rd_word(8'h0D, rv);
    chk("offs", 24'h008000, {8'h00, rv});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(5000 * 50);
    fail_count++;
    test_done();
  end
  initial begin
    void'($urandom(25570));
    do_reset();
    for (int i = 0; i < 12; i++) begin
      rd = $urandom;
      if (i % 4 == 0)
        rd = 24'h7FF000 + (rd & 24'h001FFE);
      run_raw(2'(i % 4), rd);
    end
    $display("test results done");
    @(negedge core_clk);
    offs_cal_start = 1'b1;
    @(negedge core_clk);
    offs_cal_start = 1'b0;
    chk("cal_busy", 24'h000001, {23'h0, cal_busy_reg});
    pulse_raw(2'h0, 24'h801000);
    chk("cal_res_valid", 24'h000000, {23'h0, res_valid_reg});
    offs_m = 'h8040;
    u_ccs_host_model.rd_word(8'h0D, rv);
    chk("offs", 24'h008040, {8'h00, rv});
    run_raw(2'h0, 24'h801000);
    u_ccs_host_model.wr_word(8'h0F, 16'h4000);
    gain_m = 'h4000;
    u_ccs_host_model.wr_word(8'h0D, 16'h7FC0);
    offs_m = 'h7FC0;
    run_raw(2'h0, 24'h7FF800);
    @(negedge core_clk);
    gain_cal_start = 1'b1;
    @(negedge core_clk);
    gain_cal_start = 1'b0;
    chk("gain_cal_busy", 24'h000001, {23'h0, cal_busy_reg});
    pulse_raw(2'h0, 24'h800010);
    chk("gain_cal_valid", 24'h000000, {23'h0, res_valid_reg});
    chk("gain_cal_done", 24'h000000, {23'h0, cal_busy_reg});
    gain_m = 'hFFFF;
    u_ccs_host_model.rd_word(8'h0F, rv);
    chk("gain", 24'h00FFFF, {8'h00, rv});
    run_raw(2'h0, 24'hF00000);
    run_raw(2'h0, 24'h100000);
    u_ccs_host_model.rd_word(8'h20, rv);
    chk("unmapped", 24'h000000, {8'h00, rv});
    $display("test calibration done");
    do_reset();
    $display("test reset done");
    test_done();
  end
endmodule // ccs_cal_scale_tb
`default_nettype wire
